// ==== design/memory_map_pkg.sv ====
// package: memory map, vector table and port register constants
// Operation
// R01 - decoder spans one 64K byte space using the 16-bit core address
// R02 - 128 byte register region kept apart from RAM of up to 2 Kbytes
// R03 - stack lies in RAM from 0100h to 01ffh, 256 bytes at most
// R04 - map holds 60 byte display RAM and up to 24 Kbytes program memory
// R05 - vectors at the top; reset vector pair at fffe-ffffh
// R06 - software trap vector pair at fffc-fffdh
// R07 - non-maskable external interrupt vector pair at fffa-fffbh
// R08 - five external vectors from fff0h (port d) up to fff8h
// R09 - port a bits 3..0 use fff8h, bits 7..4 use fff6h
// R10 - peripheral vectors ffe0h to ffeeh in the listed order
// R11 - auxiliary clock vector at ffech unused on variants without it
// R12 - port a data, direction, option at 0000h-0002h, rw, reset 00h
// R13 - address 0003h is a reserved hole with no register
// R14 - port b data, direction, option at 0004h-0006h, rw, reset 00h
// R15 - reserved register addresses: writes ignored, reads harmless
// R16 - vector pair read high byte at lower address, low byte at higher
package memory_map_pkg;

    localparam logic [15:0] reg_base = 16'h0000;
    localparam logic [15:0] reg_last = 16'h007f;
    localparam logic [15:0] ram_base = 16'h0080;
    localparam logic [15:0] ram_last = 16'h087f;
    localparam logic [15:0] stack_base = 16'h0100;
    localparam logic [15:0] stack_last = 16'h01ff;
    localparam logic [15:0] lcd_base = 16'h0880;
    localparam logic [15:0] lcd_last = 16'h08bb;
    localparam logic [15:0] prog_base = 16'ha000;
    localparam logic [15:0] prog_last = 16'hffdf;
    localparam logic [15:0] vec_base = 16'hffe0;

    localparam logic [15:0] ofs_port_a_pin_value = 16'h0000;
    localparam logic [15:0] ofs_port_a_direction = 16'h0001;
    localparam logic [15:0] ofs_port_a_option = 16'h0002;
    localparam logic [15:0] ofs_reserved_hole = 16'h0003;
    localparam logic [15:0] ofs_port_b_pin_value = 16'h0004;
    localparam logic [15:0] ofs_port_b_direction = 16'h0005;
    localparam logic [15:0] ofs_port_b_option = 16'h0006;
    localparam logic [7:0] port_reg_reset = 8'h00;
    localparam logic [7:0] reserved_read_value = 8'h00;

    localparam logic [15:0] vec_i2c = 16'hffe0;
    localparam logic [15:0] vec_async_serial_unit = 16'hffe2;
    localparam logic [15:0] vec_timer_b = 16'hffe4;
    localparam logic [15:0] vec_timer_a = 16'hffe6;
    localparam logic [15:0] vec_spi = 16'hffe8;
    localparam logic [15:0] vec_can = 16'hffea;
    localparam logic [15:0] vec_aux_clock_controller = 16'hffec;
    localparam logic [15:0] vec_main_clock_controller = 16'hffee;
    localparam logic [15:0] vec_ext_irq_port_d = 16'hfff0;
    localparam logic [15:0] vec_ext_irq_port_c = 16'hfff2;
    localparam logic [15:0] vec_ext_irq_port_b = 16'hfff4;
    localparam logic [15:0] vec_ext_irq_port_a_high = 16'hfff6;
    localparam logic [15:0] vec_ext_irq_port_a_low = 16'hfff8;
    localparam logic [15:0] vec_nmi = 16'hfffa;
    localparam logic [15:0] vec_trap = 16'hfffc;
    localparam logic [15:0] vec_reset = 16'hfffe;

    typedef enum logic [2:0]
    {
        region_reg = 3'h0,
        region_ram = 3'h1,
        region_lcd = 3'h2,
        region_prog = 3'h3,
        region_vector = 3'h4,
        region_none = 3'h5
    } region_type;

    typedef enum logic [3:0]
    {
        src_i2c = 4'h0,
        src_async_serial_unit = 4'h1,
        src_timer_b = 4'h2,
        src_timer_a = 4'h3,
        src_spi = 4'h4,
        src_can = 4'h5,
        src_aux_clock_controller = 4'h6,
        src_main_clock_controller = 4'h7,
        src_ext_irq_port_d = 4'h8,
        src_ext_irq_port_c = 4'h9,
        src_ext_irq_port_b = 4'ha,
        src_ext_irq_port_a_high = 4'hb,
        src_ext_irq_port_a_low = 4'hc,
        src_nmi = 4'hd,
        src_trap = 4'he,
        src_reset = 4'hf
    } irq_source_type;

    typedef struct packed
    {
        logic [7:0] pin_value;
        logic [7:0] direction;
        logic [7:0] option;
    } port_regs_type;

    typedef struct packed
    {
        logic reg_sel;
        logic ram_sel;
        logic stack_sel;
        logic lcd_sel;
        logic prog_sel;
        logic vector_sel;
    } selects_type;

endpackage : memory_map_pkg

// ==== design/memory_map_vector_decode.sv ====
// module: address decode, vector map and port a/b register slots
`timescale 1ns/1ps
module memory_map_vector_decode
    import memory_map_pkg::*;
#(
    parameter bit has_aux_clock = 1'b1
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // core bus
    input wire logic [15:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    // vector request
    input wire logic vec_req_i,
    input wire irq_source_type vec_src_i,
    // decode results
    output selects_type sel_o,
    output region_type region_o,
    output logic [7:0] rdata_o,
    output logic reg_hit_o,
    // vector answer
    output logic [15:0] vec_addr_o,
    output logic vec_valid_o,
    output logic vec_unused_o,
    // port register contents
    output port_regs_type port_a_o,
    output port_regs_type port_b_o
);

////////////////////////////////////////////////////////////////////////////

function automatic logic in_range(input logic [15:0] a,
    input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
endfunction : in_range

function automatic logic [15:0] vector_of(input irq_source_type s);
    unique case (s)
        src_i2c: vector_of = vec_i2c; // R10
        src_async_serial_unit: vector_of = vec_async_serial_unit; // R10
        src_timer_b: vector_of = vec_timer_b; // R10
        src_timer_a: vector_of = vec_timer_a; // R10
        src_spi: vector_of = vec_spi; // R10
        src_can: vector_of = vec_can; // R10
        src_aux_clock_controller: vector_of = vec_aux_clock_controller;
        src_main_clock_controller: vector_of = vec_main_clock_controller;
        src_ext_irq_port_d: vector_of = vec_ext_irq_port_d; // R08
        src_ext_irq_port_c: vector_of = vec_ext_irq_port_c; // R08
        src_ext_irq_port_b: vector_of = vec_ext_irq_port_b; // R08
        src_ext_irq_port_a_high: vector_of = vec_ext_irq_port_a_high; // R09
        src_ext_irq_port_a_low: vector_of = vec_ext_irq_port_a_low; // R09
        src_nmi: vector_of = vec_nmi; // R07
        src_trap: vector_of = vec_trap; // R06
        src_reset: vector_of = vec_reset; // R05
    endcase
endfunction : vector_of

////////////////////////////////////////////////////////////////////////////
// address decode

selects_type sel_ff;
selects_type nxt_sel;
region_type region_ff;
region_type nxt_region;
logic reg_hit_ff;
logic nxt_reg_hit;

always_comb
begin
    // whole 16-bit space, each address gets one region code; 08bch-9fffh fall to region_none
    nxt_sel = '0; // R01
    nxt_sel.reg_sel = in_range(addr_i, reg_base, reg_last); // R02
    nxt_sel.ram_sel = in_range(addr_i, ram_base, ram_last); // R02
    nxt_sel.stack_sel = in_range(addr_i, stack_base, stack_last); // R03
    nxt_sel.lcd_sel = in_range(addr_i, lcd_base, lcd_last); // R04
    nxt_sel.prog_sel = in_range(addr_i, prog_base, prog_last); // R04
    nxt_sel.vector_sel = (addr_i >= vec_base); // R05
    if (nxt_sel.reg_sel)
        nxt_region = region_reg;
    else if (nxt_sel.ram_sel)
        nxt_region = region_ram;
    else if (nxt_sel.lcd_sel)
        nxt_region = region_lcd;
    else if (nxt_sel.prog_sel)
        nxt_region = region_prog;
    else if (nxt_sel.vector_sel)
        nxt_region = region_vector;
    else
        nxt_region = region_none;
    nxt_reg_hit = nxt_sel.reg_sel && (rd_i || wr_i);
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        sel_ff <= '0;
        region_ff <= region_none;
        reg_hit_ff <= 1'b0;
    end
    else
    begin
        sel_ff <= nxt_sel;
        region_ff <= nxt_region;
        reg_hit_ff <= nxt_reg_hit;
    end
end

////////////////////////////////////////////////////////////////////////////
// port a and b register slots

port_regs_type port_a_ff;
port_regs_type nxt_port_a;
port_regs_type port_b_ff;
port_regs_type nxt_port_b;
logic [7:0] rdata_ff;
logic [7:0] nxt_rdata;

always_comb
begin
    nxt_port_a = port_a_ff;
    nxt_port_b = port_b_ff;
    if (wr_i)
    begin
        // the hole at 0003h and other offsets fall through untouched
        unique case (addr_i)
            ofs_port_a_pin_value: nxt_port_a.pin_value = wdata_i; // R12
            ofs_port_a_direction: nxt_port_a.direction = wdata_i; // R12
            ofs_port_a_option: nxt_port_a.option = wdata_i; // R12
            ofs_port_b_pin_value: nxt_port_b.pin_value = wdata_i; // R14
            ofs_port_b_direction: nxt_port_b.direction = wdata_i; // R14
            ofs_port_b_option: nxt_port_b.option = wdata_i; // R14
            default: ; // R15
        endcase
    end
    nxt_rdata = rdata_ff;
    if (rd_i)
    begin
        unique case (addr_i)
            ofs_port_a_pin_value: nxt_rdata = port_a_ff.pin_value; // R12
            ofs_port_a_direction: nxt_rdata = port_a_ff.direction; // R12
            ofs_port_a_option: nxt_rdata = port_a_ff.option; // R12
            ofs_reserved_hole: nxt_rdata = reserved_read_value; // R13
            ofs_port_b_pin_value: nxt_rdata = port_b_ff.pin_value; // R14
            ofs_port_b_direction: nxt_rdata = port_b_ff.direction; // R14
            ofs_port_b_option: nxt_rdata = port_b_ff.option; // R14
            default: nxt_rdata = reserved_read_value; // R15
        endcase
    end
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        port_a_ff <= {3{port_reg_reset}}; // R12
        port_b_ff <= {3{port_reg_reset}}; // R14
        rdata_ff <= reserved_read_value;
    end
    else
    begin
        port_a_ff <= nxt_port_a;
        port_b_ff <= nxt_port_b;
        rdata_ff <= nxt_rdata;
    end
end

////////////////////////////////////////////////////////////////////////////
// vector lookup; address given is the high byte, low byte follows at +1

logic [15:0] vec_addr_ff;
logic [15:0] nxt_vec_addr;
logic vec_valid_ff;
logic nxt_vec_valid;
logic vec_unused_ff;
logic nxt_vec_unused;

always_comb
begin
    nxt_vec_addr = vec_addr_ff;
    nxt_vec_valid = vec_req_i;
    nxt_vec_unused = vec_unused_ff;
    if (vec_req_i)
    begin
        nxt_vec_addr = vector_of(vec_src_i); // R16
        // variants without the aux clock leave its slot idle
        nxt_vec_unused = !has_aux_clock &&
            (vec_src_i == src_aux_clock_controller); // R11
    end
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        vec_addr_ff <= vec_reset;
        vec_valid_ff <= 1'b0;
        vec_unused_ff <= 1'b0;
    end
    else
    begin
        vec_addr_ff <= nxt_vec_addr;
        vec_valid_ff <= nxt_vec_valid;
        vec_unused_ff <= nxt_vec_unused;
    end
end

////////////////////////////////////////////////////////////////////////////

assign sel_o = sel_ff;
assign region_o = region_ff;
assign reg_hit_o = reg_hit_ff;
assign rdata_o = rdata_ff;
assign vec_addr_o = vec_addr_ff;
assign vec_valid_o = vec_valid_ff;
assign vec_unused_o = vec_unused_ff;
assign port_a_o = port_a_ff;
assign port_b_o = port_b_ff;

endmodule : memory_map_vector_decode

// ==== verification/memory_map_chk.sv ====
// checker: port assertions for the memory map decoder
`timescale 1ns/1ps
module memory_map_chk
    import memory_map_pkg::*;
#(
    parameter bit has_aux_clock = 1'b1
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // core bus and vector request
    input wire logic [15:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic vec_req_i,
    input wire irq_source_type vec_src_i,
    // design outputs
    input wire selects_type sel_o,
    input wire region_type region_o,
    input wire logic [7:0] rdata_o,
    input wire logic reg_hit_o,
    input wire logic [15:0] vec_addr_o,
    input wire logic vec_valid_o,
    input wire logic vec_unused_o,
    input wire port_regs_type port_a_o,
    input wire port_regs_type port_b_o
);
    logic reg_acc;
    assign reg_acc = (rd_i | wr_i) && addr_i <= 16'h007f;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_vec_req;
        vec_req_i;
    endsequence
    a_reg_hit: assert property (1 |=> reg_hit_o == $past(reg_acc))
        else $error("register hit wrong");
    a_stack_sel: assert property (addr_i inside {[16'h0100:16'h01ff]}
        |=> sel_o.stack_sel && sel_o.ram_sel) else $error("stack select");
    a_prog_region: assert property (addr_i inside {[16'ha000:16'hffdf]}
        |=> region_o == region_prog) else $error("program region");
    a_vec_region: assert property (addr_i >= 16'hffe0
        |=> region_o == region_vector && sel_o.vector_sel)
        else $error("vector region");
    a_vec_answer: assert property (s_vec_req |=> vec_valid_o
        && vec_addr_o == 16'hffe0 + {11'h000, $past(vec_src_i), 1'b0})
        else $error("vector answer");
    a_vec_pulse: assert property (!vec_req_i |=> !vec_valid_o)
        else $error("vector valid pulse");
    a_aux_unused: assert property (s_vec_req
        |=> vec_unused_o == ($past(vec_src_i) == src_aux_clock_controller
        && !has_aux_clock)) else $error("aux unused flag");
    a_hole_read: assert property (rd_i && addr_i == 16'h0003
        |=> rdata_o == 8'h00) else $error("hole read");
    a_hole_write: assert property (wr_i && addr_i == 16'h0003
        |=> $stable(port_a_o) && $stable(port_b_o)) else $error("hole write");
    a_dir_write: assert property (wr_i && addr_i == 16'h0001
        |=> port_a_o.direction == $past(wdata_i)) else $error("direction");
endmodule : memory_map_chk

// ==== verification/cpu_core_model.sv ====
// partner: core side driving bus cycles and vector fetches
`timescale 1ns/1ps
module cpu_core_model
    import memory_map_pkg::*;
(
    // clock
    input wire logic clk_i,
    // core bus
    output logic [15:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    // vector request
    output logic vec_req_o,
    output irq_source_type vec_src_o
);
    initial
    begin
        addr_o = 16'hffff;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        vec_req_o = 1'b0;
        vec_src_o = src_reset;
    end
    // one byte cycle; idle bus shows inverted values, not stale ones
    task access(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wr_o = w;
        rd_o = !w;
        wdata_o = d;
        @(negedge clk_i);
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : access
    task fetch(input irq_source_type s);
        @(negedge clk_i);
        vec_req_o = 1'b1;
        vec_src_o = s;
        @(negedge clk_i);
        vec_req_o = 1'b0;
        vec_src_o = irq_source_type'(~s);
    endtask : fetch
endmodule : cpu_core_model

// ==== verification/tb.sv ====
// testbench: register, decode and vector checks
`timescale 1ns/1ps
module tb;
    import memory_map_pkg::*;
    logic clk_i;
    logic rst_i;
    logic [15:0] addr_i;
    logic rd_i;
    logic wr_i;
    logic [7:0] wdata_i;
    logic vec_req_i;
    irq_source_type vec_src_i;
    selects_type sel_o;
    region_type region_o;
    logic [7:0] rdata_o;
    logic reg_hit_o;
    logic [15:0] vec_addr_o;
    logic vec_valid_o;
    logic vec_unused_o;
    port_regs_type port_a_o;
    port_regs_type port_b_o;
    logic [15:0] vec_addr_full;
    logic vec_unused_full;
    int err_total = 0;
    int checked = 0;
    logic [15:0] da [12] = '{16'h0000, 16'h007f, 16'h0080, 16'h0100,
        16'h01ff, 16'h0200, 16'h087f, 16'h0880, 16'h08bb, 16'h08bc,
        16'ha000, 16'hffdf};
    region_type dr [12] = '{region_reg, region_reg, region_ram, region_ram,
        region_ram, region_ram, region_ram, region_lcd, region_lcd,
        region_none, region_prog, region_prog};
    cpu_core_model u_cpu_core_model (.clk_i(clk_i), .addr_o(addr_i),
        .rd_o(rd_i), .wr_o(wr_i), .wdata_o(wdata_i), .vec_req_o(vec_req_i),
        .vec_src_o(vec_src_i));
    // variant without aux clock, the awkward vector case
    memory_map_vector_decode #(.has_aux_clock(1'b0))
        u_memory_map_vector_decode (.clk_i(clk_i), .rst_i(rst_i),
        .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i),
        .vec_req_i(vec_req_i), .vec_src_i(vec_src_i), .sel_o(sel_o),
        .region_o(region_o), .rdata_o(rdata_o), .reg_hit_o(reg_hit_o),
        .vec_addr_o(vec_addr_o), .vec_valid_o(vec_valid_o),
        .vec_unused_o(vec_unused_o), .port_a_o(port_a_o),
        .port_b_o(port_b_o));
    // default variant with the aux clock, its vector slot stays in use
    memory_map_vector_decode u_memory_map_vector_decode_aux (.clk_i(clk_i),
        .rst_i(rst_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i),
        .wdata_i(wdata_i), .vec_req_i(vec_req_i), .vec_src_i(vec_src_i),
        .sel_o(), .region_o(), .rdata_o(), .reg_hit_o(),
        .vec_addr_o(vec_addr_full), .vec_valid_o(),
        .vec_unused_o(vec_unused_full), .port_a_o(), .port_b_o());
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk
    task rd(input logic [15:0] a, input logic [7:0] e);
        u_cpu_core_model.access(1'b0, a, 8'h00);
        chk(rdata_o, e);
    endtask : rd
    task finish_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial
    begin
        #400000;
        err_total++;
        finish_test();
    end
    initial
    begin
        rst_i = 1'b1;
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        for (int i = 0; i < 7; i++)
            rd(16'(i), 8'h00);
        $display("test reset done");
        for (int i = 0; i < 7; i++)
            u_cpu_core_model.access(1'b1, 16'(i), 8'(8'h11 * (i + 1)));
        u_cpu_core_model.access(1'b1, 16'h0007, 8'hee);
        for (int i = 0; i < 7; i++)
            rd(16'(i), (i == 3) ? 8'h00 : 8'(8'h11 * (i + 1)));
        chk(port_a_o, 24'h112233);
        chk(port_b_o, 24'h556677);
        $display("test registers done");
        for (int i = 0; i < 12; i++)
        begin
            u_cpu_core_model.access(1'b0, da[i], 8'h00);
            chk(region_o, dr[i]);
            chk(reg_hit_o, da[i] <= 16'h007f);
            chk(sel_o.stack_sel, da[i] inside {[16'h0100:16'h01ff]});
            chk(sel_o.ram_sel, da[i] inside {[16'h0080:16'h087f]});
            chk(sel_o.lcd_sel, da[i] inside {[16'h0880:16'h08bb]});
            chk(sel_o.prog_sel, da[i] inside {[16'ha000:16'hffdf]});
        end
        $display("test decode done");
        for (int i = 0; i < 16; i++)
        begin
            u_cpu_core_model.fetch(irq_source_type'(i));
            chk(vec_valid_o, 1'b1);
            chk(vec_addr_o, 16'hffe0 + 16'(2 * i));
            chk(vec_unused_o, i == 6);
            chk(vec_unused_full, 1'b0);
            chk(vec_addr_full, 16'hffe0 + 16'(2 * i));
        end
        @(negedge clk_i);
        chk(vec_valid_o, 1'b0);
        chk(vec_addr_o, 16'hfffe);
        $display("test vectors done");
        rst_i = 1'b1;
        @(negedge clk_i);
        rst_i = 1'b0;
        chk(port_a_o, 24'h000000);
        chk(port_b_o, 24'h000000);
        $display("test second reset done");
        finish_test();
    end
endmodule : tb
bind memory_map_vector_decode memory_map_chk #(.has_aux_clock(has_aux_clock))
    u_memory_map_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .vec_req_i(vec_req_i),
    .vec_src_i(vec_src_i), .sel_o(sel_o), .region_o(region_o),
    .rdata_o(rdata_o), .reg_hit_o(reg_hit_o), .vec_addr_o(vec_addr_o),
    .vec_valid_o(vec_valid_o), .vec_unused_o(vec_unused_o),
    .port_a_o(port_a_o), .port_b_o(port_b_o));
